//--- common/adc_ctrl_pkg.sv
// shared constants, types and register map of the converter control block
package adc_ctrl_pkg;

	// register indexes; byte address is four times the index
	localparam logic [9:0] IDX_RESULT_LOW   = 10'h078;
	localparam logic [9:0] IDX_RESULT_HIGH  = 10'h079;
	localparam logic [9:0] IDX_CTRL_STATUS  = 10'h07A;
	localparam logic [9:0] IDX_TRIG_SOURCE  = 10'h07B;
	localparam logic [9:0] IDX_CHAN_REF_SEL = 10'h07C;

	// converter_control_status fields
	localparam int CTRL_EN_BIT    = 7;
	localparam int CTRL_START_BIT = 6;
	localparam int CTRL_AUTO_BIT  = 5;
	localparam int CTRL_FLAG_BIT  = 4;
	localparam int CTRL_IE_BIT    = 3;
	localparam int CTRL_DIV_LSB   = 0;

	// channel_reference_select fields
	localparam int MUX_REF_LSB  = 6;
	localparam int MUX_LEFT_BIT = 5;
	localparam int MUX_CHAN_LSB = 0;

	// values after reset
	localparam logic [7:0]  CTRL_RST   = 8'h00;
	localparam logic [7:0]  MUX_RST    = 8'h00;
	localparam logic [2:0]  TRIG_RST   = 3'h0;
	localparam logic [9:0]  RESULT_RST = 10'h000;

	// conversion lengths in converter clock cycles
	localparam int         CONV_CYC_FIRST  = 25;
	localparam int         CONV_CYC_NORMAL = 13;
	localparam logic [4:0] CONV_LAST_FIRST  = 5'(CONV_CYC_FIRST - 1);
	localparam logic [4:0] CONV_LAST_NORMAL = 5'(CONV_CYC_NORMAL - 1);

	// result code limits
	localparam logic [9:0] SE_MAX   = 10'h3FF;
	localparam logic [9:0] DIFF_MAX = 10'h1FF;
	localparam logic [9:0] DIFF_MIN = 10'h200;

	// channel codes for the two single-ended internal sources
	localparam logic [4:0] CHAN_BANDGAP = 5'h1E;
	localparam logic [4:0] CHAN_GROUND  = 5'h1F;

	// trigger source code for free running
	localparam logic [2:0] TRIG_FREE_RUN = 3'h0;

	typedef enum logic [1:0] {
		REF_EXT_PIN  = 2'h0,
		REF_SUPPLY   = 2'h1,
		REF_RESERVED = 2'h2,
		REF_INTERNAL = 2'h3
	} ref_sel_t;

	typedef enum logic [2:0] {
		ST_OFF  = 3'b001,
		ST_IDLE = 3'b010,
		ST_CONV = 3'b100
	} conv_state_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} apb_rsp_t;

	typedef struct packed {
		logic       power;
		ref_sel_t   ref_sel;
		logic       ref_valid;
		logic [4:0] channel;
		logic       differential;
		logic       sample;
	} ana_ctrl_t;

endpackage

//--- dv/sar_array_model.sv
// behavioural sampling array that captures the analog level on each sample pulse
`timescale 1ns/100ps
module sar_array_model (
	// clock
	input  wire logic                    i_sys_clk,
	// control from the block
	input  wire adc_ctrl_pkg::ana_ctrl_t i_ana,
	// level applied by the bench
	input  wire logic [10:0]             i_level,
	// code towards the block
	output logic [10:0]                  o_sar_code
);
	import adc_ctrl_pkg::*;
	logic [10:0] hold_ff = 11'h000;

	always_ff @(posedge i_sys_clk) begin
		if (i_ana.sample) begin
			hold_ff <= i_level;
		end
	end

	// powered off the array no longer holds a valid code
	assign o_sar_code = i_ana.power ? hold_ff : ~hold_ff;
endmodule // sar_array_model

//--- dv/testbench.sv
// register level bench for the converter control block
`timescale 1ns/100ps
module testbench;
	import adc_ctrl_pkg::*;
	logic        sys_clk;
	logic        srst;
	apb_req_t    req;
	apb_rsp_t    rsp;
	ana_ctrl_t   ana;
	logic [10:0] level;
	logic [10:0] sar_code;
	logic [7:1]  trig;
	logic        gie;
	logic        ack;
	logic        irq;
	int          err_total = 0;
	int          checks = 0;
	int          cyc = 0;
	int          t0;
	int          e;
	logic [10:0] dv[3] = '{11'h7FF, 11'h400, 11'h2BC};
	logic [9:0]  de[3] = '{10'h3FF, 10'h200, 10'h1FF};

	adc_control_and_result adc_control_and_result_i (.i_sys_clk(sys_clk), .i_srst(srst),
		.i_apb(req), .o_apb(rsp), .i_sar_code(sar_code), .o_ana(ana), .i_trig_flags(trig),
		.i_global_irq_en(gie), .i_irq_ack(ack), .o_done_irq(irq));
	sar_array_model sar_array_model_i (.i_sys_clk(sys_clk), .i_ana(ana), .i_level(level),
		.o_sar_code(sar_code));

	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk) cyc <= cyc + 1;

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic chk_rng(input string nm, input int lo, input int hi, input int got);
		checks++;
		if (got < lo || got > hi) begin
			err_total++;
			$display("[FAIL] %s expected %0d..%0d seen %0d", nm, lo, hi, got);
		end
	endtask

	// one apb transfer; for reads dat is the expected byte
	task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] dat,
			input logic eerr = 1'b0);
		int n;
		n = 0;
		@(posedge sys_clk);
		req.psel    <= 1'b1;
		req.penable <= 1'b0;
		req.pwrite  <= w;
		req.paddr   <= {idx, 2'b00};
		req.pwdata  <= {24'h000000, dat};
		@(posedge sys_clk);
		req.penable <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
		end while (rsp.pready !== 1'b1 && n < 20);
		chk("pready", 32'h1, 32'(rsp.pready));
		chk($sformatf("pslverr %h", idx), 32'(eerr), 32'(rsp.pslverr));
		if (!w)
			chk($sformatf("read %h", idx), {24'h000000, dat}, rsp.prdata);
		req.psel    <= 1'b0;
		req.penable <= 1'b0;
	endtask

	task automatic start(input logic [7:0] ctl, input logic [10:0] v);
		level <= v;
		apb(1'b1, IDX_CTRL_STATUS, ctl);
		t0 = cyc;
	endtask

	task automatic wait_done(input string nm, input int exp);
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 20000) begin
			@(posedge sys_clk);
			n++;
		end
		chk_rng(nm, exp, exp + 6, cyc - t0);
	endtask

	task automatic clear_irq;
		@(posedge sys_clk) ack <= 1'b1;
		@(posedge sys_clk) ack <= 1'b0;
		repeat (3) @(posedge sys_clk);
		chk("irq cleared", 32'h0, 32'(irq));
	endtask

	task automatic conclude;
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge sys_clk);
		err_total++;
		conclude();
	end

	initial begin
		req = '0;
		srst = 1'b1;
		level = 11'h000;
		trig = 7'h00;
		gie = 1'b1;
		ack = 1'b0;
		repeat (2) @(posedge sys_clk);
		srst <= 1'b0;
		for (int i = 0; i < 5; i++)
			apb(1'b0, IDX_RESULT_LOW + 10'(i), 8'h00);
		apb(1'b0, 10'h07D, 8'h00, 1'b1);
		apb(1'b1, IDX_RESULT_HIGH, 8'hFF);
		apb(1'b0, IDX_RESULT_HIGH, 8'h00);
		$display("test reset done");

		apb(1'b1, IDX_CHAN_REF_SEL, 8'h83);
		apb(1'b0, IDX_CHAN_REF_SEL, 8'h83);
		start(8'hC8, 11'h2A5);
		apb(1'b0, IDX_CTRL_STATUS, 8'hC8);
		apb(1'b1, IDX_CHAN_REF_SEL, 8'h47);
		chk("channel latched", 32'h3, 32'(ana.channel));
		chk("reference latched", 32'(REF_RESERVED), 32'(ana.ref_sel));
		chk("reference valid", 32'h0, 32'(ana.ref_valid));
		wait_done("first conversion", 50);
		apb(1'b0, IDX_CTRL_STATUS, 8'h98);
		apb(1'b0, IDX_RESULT_LOW, 8'hA5);
		apb(1'b0, IDX_RESULT_HIGH, 8'h02);
		apb(1'b1, IDX_CHAN_REF_SEL, 8'h67);
		apb(1'b0, IDX_RESULT_LOW, 8'h40);
		apb(1'b0, IDX_RESULT_HIGH, 8'hA9);
		apb(1'b1, IDX_CTRL_STATUS, 8'h88);
		apb(1'b0, IDX_CTRL_STATUS, 8'h98);
		apb(1'b1, IDX_CTRL_STATUS, 8'h98);
		apb(1'b0, IDX_CTRL_STATUS, 8'h88);
		$display("test first conversion done");

		apb(1'b1, IDX_CHAN_REF_SEL, 8'h47);
		for (int d = 1; d < 8; d++) begin
			start(8'hC8 | 8'(d), 11'(d * 160));
			if (d == 7) begin
				apb(1'b1, IDX_CHAN_REF_SEL, 8'h67);
				apb(1'b0, IDX_RESULT_HIGH, 8'hF0);
				apb(1'b1, IDX_CHAN_REF_SEL, 8'h47);
			end
			wait_done("divided conversion", 13 * ((d < 2) ? 2 : (1 << d)));
			e = (d * 160 > 1023) ? 1023 : d * 160;
			apb(1'b0, IDX_RESULT_LOW, 8'(e));
			apb(1'b0, IDX_RESULT_HIGH, 8'(e >> 8));
			clear_irq();
		end
		$display("test prescaler done");

		apb(1'b1, IDX_CHAN_REF_SEL, 8'h50);
		for (int i = 0; i < 3; i++) begin
			start(8'hC8, dv[i]);
			@(posedge sys_clk);
			chk("differential", 32'h1, 32'(ana.differential));
			wait_done("differential conversion", 26);
			apb(1'b0, IDX_RESULT_LOW, de[i][7:0]);
			apb(1'b0, IDX_RESULT_HIGH, {6'h00, de[i][9:8]});
			clear_irq();
		end
		apb(1'b0, IDX_RESULT_LOW, 8'hFF);
		start(8'hC8, 11'h001);
		wait_done("locked conversion", 26);
		apb(1'b0, IDX_RESULT_HIGH, 8'h01);
		apb(1'b0, IDX_RESULT_LOW, 8'hFF);
		apb(1'b0, IDX_RESULT_HIGH, 8'h01);
		clear_irq();
		$display("test differential and lock done");

		apb(1'b1, IDX_CHAN_REF_SEL, 8'h5F);
		start(8'hC8, 11'h000);
		@(posedge sys_clk);
		chk("ground channel", 32'(CHAN_GROUND), 32'(ana.channel));
		chk("ground single-ended", 32'h0, 32'(ana.differential));
		apb(1'b1, IDX_CTRL_STATUS, 8'h08);
		repeat (60) @(posedge sys_clk);
		chk("abort irq", 32'h0, 32'(irq));
		chk("power off", 32'h0, 32'(ana.power));
		apb(1'b0, IDX_CTRL_STATUS, 8'h08);
		$display("test abort done");

		apb(1'b1, IDX_CHAN_REF_SEL, 8'h5E);
		apb(1'b1, IDX_TRIG_SOURCE, 8'h01);
		apb(1'b1, IDX_CTRL_STATUS, 8'hA8);
		level <= 11'h010;
		@(posedge sys_clk) trig <= 7'h01;
		t0 = cyc;
		wait_done("triggered conversion", 50);
		chk("bandgap single-ended", 32'h0, 32'(ana.differential));
		trig <= 7'h00;
		apb(1'b1, IDX_TRIG_SOURCE, 8'h00);
		repeat (80) @(posedge sys_clk);
		apb(1'b0, IDX_CTRL_STATUS, 8'hB8);
		clear_irq();
		start(8'hE8, 11'h010);
		wait_done("free running", 26);
		apb(1'b0, IDX_CTRL_STATUS, 8'hF8);
		repeat (60) @(posedge sys_clk);
		apb(1'b0, IDX_CTRL_STATUS, 8'hB8);
		apb(1'b0, IDX_RESULT_LOW, 8'h10);
		apb(1'b0, IDX_RESULT_HIGH, 8'h00);
		$display("test auto trigger done");
		conclude();
	end
endmodule // testbench

//--- hw/adc_clk_divider.sv
// converter clock prescaler producing one tick per converter clock period
`timescale 1ns/100ps
module adc_clk_divider (
	// clock and reset
	input  wire logic       i_sys_clk,
	input  wire logic       i_srst,
	// control
	input  wire logic       i_run,
	input  wire logic [2:0] i_div_sel,
	// converter clock tick
	output logic            o_tick
);
	logic [6:0] cnt_ff;
	logic [6:0] limit;
	logic [2:0] shamt;

	// codes 0 and 1 both divide by two
	always_comb begin
		shamt = (i_div_sel < 3'h2) ? 3'h1 : i_div_sel;
		limit = 7'((8'h01 << shamt) - 8'h01); // R16
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_srst || !i_run) begin
			cnt_ff <= 7'h00;
		end else if (cnt_ff == limit) begin
			cnt_ff <= 7'h00;
		end else begin
			cnt_ff <= cnt_ff + 7'h01;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			o_tick <= 1'b0;
		end else begin
			o_tick <= i_run && (cnt_ff == limit); // R16
		end
	end
endmodule // adc_clk_divider

//--- hw/adc_control_and_result.sv
// control, trigger, result and register logic of the 10-bit converter
//
// How it works
// R1: single-ended result unsigned 10 bits, clamped to 0x3FF at the reference.
// R2: differential result two's complement -512..+511, clamped at both the positive and the negative limit.
// R3: reference select 00 pin, 01 supply, 10 reserved, 11 internal 1.1V.
// R4: reference and channel changes apply only to the next conversion.
// R5: left adjust changes result presentation at once, even mid conversion.
// R6: right adjusted: low byte bits 7:0, high byte bits 9:8, rest zero.
// R7: channel codes decode to single, differential, bandgap and ground inputs.
// R8: enable powers converter; clearing it aborts a running conversion.
// R9: writing one to start begins a conversion; software only kicks free running.
// R10: first conversion after enabling takes 25 converter cycles, others 13.
// R11: start bit reads one while converting; writing zero does nothing.
// R12: with auto trigger, rising edge of selected trigger starts a conversion.
// R13: done flag sets when a conversion finishes and result is stored.
// R14: done flag clears on interrupt acknowledge or written one; zero ignored.
// R15: interrupt raised while flag, its enable and global enable are set.
// R16: prescaler divides by 2,2,4,8,16,32,64,128 to make converter clock.
// R17: left adjusted: high byte bits 9:2, low byte 7:6 bits 1:0.
// R18: reading low byte freezes result until high byte is read.
// R19: trigger source 0 is free running; switching to it is no trigger.
// R20: free running restarts on each rising edge of the done flag.
// R21: reserved reference code stays readable, marked undefined, raises no error.
//
// The APB slave port is this design's own decision.
`timescale 1ns/100ps
module adc_control_and_result (
	// clock and reset
	input  wire logic                     i_sys_clk,
	input  wire logic                     i_srst,
	// register bus
	input  wire adc_ctrl_pkg::apb_req_t   i_apb,
	output      adc_ctrl_pkg::apb_rsp_t   o_apb,
	// sampling array
	input  wire logic [10:0]              i_sar_code,
	output      adc_ctrl_pkg::ana_ctrl_t  o_ana,
	// triggers and interrupt
	input  wire logic [7:1]               i_trig_flags,
	input  wire logic                     i_global_irq_en,
	input  wire logic                     i_irq_ack,
	output logic                          o_done_irq
);
	import adc_ctrl_pkg::*;

	logic        enable_ff;
	logic        auto_ff;
	logic        ie_ff;
	logic [2:0]  div_sel_ff;
	logic        flag_ff;
	logic [1:0]  ref_ff;
	logic        left_ff;
	logic [4:0]  chan_ff;
	logic [2:0]  trig_src_ff;
	logic [2:0]  src_prev_ff;
	logic        trig_prev_ff;
	logic [9:0]  result_ff;
	logic        lock_ff;
	logic        init_ff;
	logic        long_ff;
	logic [4:0]  tick_cnt_ff;
	conv_state_t state_ff;
	ana_ctrl_t   ana_ff;
	apb_rsp_t    rsp_ff;

	logic        acc;
	logic        fire;
	logic        aligned;
	logic [9:0]  idx;
	logic [7:0]  wd;
	logic        wr_ctrl;
	logic        wr_mux;
	logic        wr_trig;
	logic        rd_low;
	logic        rd_high;
	logic        disable_wr;
	logic        tick;
	logic        busy;
	logic        conv_done;
	logic        sw_start;
	logic        auto_start;
	logic        start_ok;
	logic [7:0]  trig_vec;
	logic        trig_now;
	logic        trig_edge;
	logic [9:0]  conv_code;
	logic [7:0]  lo_view;
	logic [7:0]  hi_view;
	logic [7:0]  ctrl_view;
	logic [7:0]  rd_view;
	logic        rd_hit;

	// bus decode: access phase takes two cycles, pready on the second
	assign acc     = i_apb.psel && i_apb.penable && !rsp_ff.pready;
	assign fire    = i_apb.psel && i_apb.penable && rsp_ff.pready;
	assign aligned = (i_apb.paddr[1:0] == 2'h0);
	assign idx     = i_apb.paddr[11:2];
	assign wd      = i_apb.pwdata[7:0];
	assign wr_ctrl = fire && i_apb.pwrite && aligned && (idx == IDX_CTRL_STATUS);
	assign wr_mux  = fire && i_apb.pwrite && aligned && (idx == IDX_CHAN_REF_SEL);
	assign wr_trig = fire && i_apb.pwrite && aligned && (idx == IDX_TRIG_SOURCE);
	assign rd_low  = acc && !i_apb.pwrite && aligned && (idx == IDX_RESULT_LOW);
	assign rd_high = acc && !i_apb.pwrite && aligned && (idx == IDX_RESULT_HIGH);

	assign disable_wr = wr_ctrl && !wd[CTRL_EN_BIT]; // R8
	assign busy       = (state_ff == ST_CONV);

	adc_clk_divider u_div (
		.i_sys_clk (i_sys_clk),
		.i_srst    (i_srst),
		.i_run     (busy),
		.i_div_sel (div_sel_ff),
		.o_tick    (tick)
	);

	// a disable in the completing cycle wins and drops the result
	assign conv_done = busy && tick && !disable_wr &&
		(tick_cnt_ff == (long_ff ? CONV_LAST_FIRST : CONV_LAST_NORMAL)); // R10

	// trigger selection; source 0 watches our own done flag
	assign trig_vec  = {i_trig_flags, flag_ff}; // R20
	assign trig_now  = trig_vec[trig_src_ff]; // R12
	assign trig_edge = trig_now && !trig_prev_ff &&
		!((trig_src_ff == TRIG_FREE_RUN) && (src_prev_ff != TRIG_FREE_RUN)); // R19

	assign sw_start   = wr_ctrl && wd[CTRL_START_BIT] && wd[CTRL_EN_BIT]; // R9
	assign auto_start = auto_ff && enable_ff && trig_edge; // R12
	assign start_ok   = (sw_start || auto_start) && !busy && !disable_wr;

	// result views follow left adjust live
	always_comb begin
		if (left_ff) begin
			hi_view = result_ff[9:2]; // R17
			lo_view = {result_ff[1:0], 6'h00}; // R17
		end else begin
			hi_view = {6'h00, result_ff[9:8]}; // R6
			lo_view = result_ff[7:0]; // R6
		end
	end

	assign ctrl_view = {enable_ff, busy, auto_ff, flag_ff, ie_ff, div_sel_ff}; // R11

	always_comb begin
		rd_view = 8'h00;
		rd_hit  = aligned;
		case (idx)
			IDX_RESULT_LOW:   rd_view = lo_view; // R5
			IDX_RESULT_HIGH:  rd_view = hi_view; // R5
			IDX_CTRL_STATUS:  rd_view = ctrl_view;
			IDX_TRIG_SOURCE:  rd_view = {5'h00, trig_src_ff};
			IDX_CHAN_REF_SEL: rd_view = {ref_ff, left_ff, chan_ff}; // R21
			default:          rd_hit  = 1'b0;
		endcase
	end

	// raw array code: single-ended unsigned, differential signed 11 bits
	always_comb begin
		if (ana_ff.differential) begin
			if (!i_sar_code[10] && i_sar_code[9]) begin
				conv_code = DIFF_MAX; // R2
			end else if (i_sar_code[10] && !i_sar_code[9]) begin
				conv_code = DIFF_MIN; // R2
			end else begin
				conv_code = i_sar_code[9:0]; // R2
			end
		end else begin
			conv_code = i_sar_code[10] ? SE_MAX : i_sar_code[9:0]; // R1
		end
	end

	// bus response
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			rsp_ff <= '0;
		end else begin
			rsp_ff.pready <= acc;
			if (acc) begin
				rsp_ff.prdata  <= i_apb.pwrite ? 32'h0000_0000 : {24'h00_0000, rd_view};
				rsp_ff.pslverr <= !rd_hit;
			end else if (fire) begin
				rsp_ff.pslverr <= 1'b0;
			end
		end
	end

	// control fields of converter_control_status
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			enable_ff  <= CTRL_RST[CTRL_EN_BIT];
			auto_ff    <= CTRL_RST[CTRL_AUTO_BIT];
			ie_ff      <= CTRL_RST[CTRL_IE_BIT];
			div_sel_ff <= CTRL_RST[CTRL_DIV_LSB +: 3];
		end else if (wr_ctrl) begin
			enable_ff  <= wd[CTRL_EN_BIT]; // R8
			auto_ff    <= wd[CTRL_AUTO_BIT];
			ie_ff      <= wd[CTRL_IE_BIT];
			div_sel_ff <= wd[CTRL_DIV_LSB +: 3]; // R16
		end
	end

	// done flag: completion wins over any clear
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			flag_ff <= CTRL_RST[CTRL_FLAG_BIT];
		end else if (conv_done) begin
			flag_ff <= 1'b1; // R13
		end else if (i_irq_ack || (wr_ctrl && wd[CTRL_FLAG_BIT])) begin
			flag_ff <= 1'b0; // R14
		end
	end

	// channel_reference_select and trigger source
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			ref_ff  <= MUX_RST[MUX_REF_LSB +: 2];
			left_ff <= MUX_RST[MUX_LEFT_BIT];
			chan_ff <= MUX_RST[MUX_CHAN_LSB +: 5];
		end else if (wr_mux) begin
			ref_ff  <= wd[MUX_REF_LSB +: 2]; // R21
			left_ff <= wd[MUX_LEFT_BIT]; // R5
			chan_ff <= wd[MUX_CHAN_LSB +: 5];
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			trig_src_ff  <= TRIG_RST;
			src_prev_ff  <= TRIG_RST;
			trig_prev_ff <= 1'b0;
		end else begin
			if (wr_trig) begin
				trig_src_ff <= wd[2:0];
			end
			src_prev_ff  <= trig_src_ff;
			trig_prev_ff <= trig_now;
		end
	end

	// conversion sequencing
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			state_ff <= ST_OFF;
		end else if (disable_wr) begin
			state_ff <= ST_OFF; // R8
		end else if (start_ok) begin
			state_ff <= ST_CONV; // R9
		end else begin
			case (state_ff)
				ST_OFF:  state_ff <= enable_ff ? ST_IDLE : ST_OFF;
				ST_IDLE: state_ff <= enable_ff ? ST_IDLE : ST_OFF;
				ST_CONV: state_ff <= conv_done ? ST_IDLE : ST_CONV; // R11
				default: state_ff <= ST_OFF;
			endcase
		end
	end

	// first conversion after enabling runs long
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			init_ff <= 1'b1;
			long_ff <= 1'b0;
		end else if (start_ok) begin
			init_ff <= 1'b0;
			long_ff <= init_ff; // R10
		end else if (!enable_ff) begin
			init_ff <= 1'b1;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_srst || start_ok) begin
			tick_cnt_ff <= 5'h00;
		end else if (busy && tick) begin
			tick_cnt_ff <= tick_cnt_ff + 5'h01;
		end
	end

	// settings reach the array only at conversion start
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			ana_ff <= '0;
		end else begin
			ana_ff.power  <= enable_ff && !disable_wr;
			ana_ff.sample <= start_ok;
			if (start_ok) begin
				ana_ff.ref_sel      <= ref_sel_t'(ref_ff); // R4 R3
				ana_ff.ref_valid    <= (ref_ff != REF_RESERVED); // R21
				ana_ff.channel      <= chan_ff; // R4
				ana_ff.differential <= chan_ff[4] && (chan_ff != CHAN_BANDGAP) &&
					(chan_ff != CHAN_GROUND); // R7
			end
		end
	end

	// result store with read lock
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			result_ff <= RESULT_RST;
		end else if (conv_done && !lock_ff) begin
			result_ff <= conv_code; // R18
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			lock_ff <= 1'b0;
		end else if (rd_high) begin
			lock_ff <= 1'b0; // R18
		end else if (rd_low) begin
			lock_ff <= 1'b1; // R18
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			o_done_irq <= 1'b0;
		end else begin
			o_done_irq <= flag_ff && ie_ff && i_global_irq_en; // R15
		end
	end

	assign o_apb = rsp_ff;
	assign o_ana = ana_ff;

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_srst);

	AST_START_BUSY: assert property (start_ok |=> busy && ana_ff.sample) // R9
		else $error("accepted start did not begin a conversion");
	AST_START_CLEARS: assert property (conv_done |=> !ctrl_view[CTRL_START_BIT]) // R11
		else $error("start bit still set after completion");
	AST_LONG_FIRST: assert property (start_ok && !enable_ff |=> long_ff) // R10
		else $error("first conversion after enable not long");
	AST_SHORT_NEXT: assert property (start_ok && !init_ff |=> !long_ff) // R10
		else $error("later conversion not short");
	AST_FLAG_SET: assert property (conv_done |=> flag_ff && !busy) // R13
		else $error("done flag not set at completion");
	AST_FLAG_ACK: assert property (i_irq_ack && !conv_done |=> !flag_ff) // R14
		else $error("acknowledge did not clear done flag");
	AST_IRQ: assert property (flag_ff && ie_ff && i_global_irq_en |=> o_done_irq) // R15
		else $error("interrupt missing");
	AST_NO_IRQ: assert property (!flag_ff |=> !o_done_irq) // R15
		else $error("interrupt without flag");
	AST_ABORT: assert property (disable_wr && !flag_ff |=> state_ff == ST_OFF && !flag_ff) // R8
		else $error("disable did not abort conversion");
	AST_HELD: assert property (busy && $past(busy) |-> $stable(ana_ff.channel) && // R4
		$stable(ana_ff.ref_sel))
		else $error("array settings changed mid conversion");
	AST_LOCK: assert property (lock_ff && conv_done |=> $stable(result_ff)) // R18
		else $error("locked result was overwritten");
	AST_SE_CLAMP: assert property (conv_done && !lock_ff && !ana_ff.differential && // R1
		i_sar_code[10] |=> result_ff == SE_MAX)
		else $error("single-ended clamp wrong");
	AST_DIFF_CLAMP: assert property (conv_done && !lock_ff && ana_ff.differential && // R2
		!i_sar_code[10] && i_sar_code[9] |=> result_ff == DIFF_MAX)
		else $error("differential clamp wrong");
	AST_LEFT_VIEW: assert property (fire && !i_apb.pwrite && aligned && left_ff && // R17
		(idx == IDX_RESULT_HIGH) |-> rsp_ff.prdata[7:0] == $past(result_ff[9:2]))
		else $error("left adjusted high byte read wrong");
	AST_FREE_SWITCH: assert property ((trig_src_ff == TRIG_FREE_RUN) && !busy && // R19
		(src_prev_ff != TRIG_FREE_RUN) && !sw_start |=> !busy)
		else $error("switch to free running made a trigger");

	COV_LONG_DONE: cover property (start_ok && init_ff ##[1:1000] conv_done);
	COV_FREE_RUN: cover property (conv_done ##[1:4] auto_start && trig_src_ff == TRIG_FREE_RUN);
	COV_LOCK_DROP: cover property (lock_ff && conv_done);
	COV_ABORT: cover property (busy && disable_wr);
endmodule // adc_control_and_result
